// file: ccce_pkg.sv
// constants, types and behaviour notes for the call / zero / kick / invert execution slice
package ccce_pkg;

  localparam int PC_W       = 21;
  localparam int DADDR_W    = 12;
  localparam int WDT_W      = 8;
  localparam int POST_W     = 7;
  localparam logic [PC_W-1:0]    PC_RST     = 21'h000000;
  localparam logic [PC_W-1:0]    CALL_RET   = 21'h000004;
  localparam logic [PC_W-1:0]    PC_STEP    = 21'h000002;
  localparam logic [7:0]         ACC_RST    = 8'h00;
  localparam logic [7:0]         FLAGS_RST  = 8'h00;
  localparam logic [3:0]         BANK_RST   = 4'h0;
  localparam logic [WDT_W-1:0]   WDT_RST    = 8'h00;
  localparam logic [POST_W-1:0]  POST_RST   = 7'h00;
  localparam logic [POST_W-1:0]  POST_MAX   = 7'h7f;
  localparam logic [WDT_W-1:0]   WDT_MAX    = 8'hff;
  localparam int FLAG_N     = 4;
  localparam int FLAG_Z     = 2;
  localparam logic [6:0]  OPC_ZERO   = 7'h35;
  localparam logic [5:0]  OPC_INVERT = 6'h07;
  localparam logic [6:0]  OPC_CALL   = 7'h76;
  localparam logic [3:0]  OPC_CALL2  = 4'hf;
  localparam logic [15:0] OPC_KICK   = 16'h0004;
  localparam int BIT_FAST   = 8;
  localparam int BIT_DEST   = 9;
  localparam int BIT_ACCESS = 8;
  localparam logic [3:0]  ACC_BANK_LO = 4'h0;
  localparam logic [3:0]  ACC_BANK_HI = 4'hf;

  typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROC, PH_WRITE} ccce_phase_t;
  typedef enum logic [2:0] {OP_NONE, OP_ZERO, OP_KICK, OP_INVERT, OP_CALL} ccce_op_t;

  // one data register file request, valid for one phase
  typedef struct packed {
    logic               rd;
    logic               wr;
    logic [DADDR_W-1:0] addr;
    logic [7:0]         wdata;
  } ccce_req_t;

endpackage

// file: ccce_exec.sv
// execution slice: two-word call, zero/invert file register, watchdog kick
`timescale 1ns/1ns
module ccce_exec (
  input  wire logic                       ref_clk_in,
  input  wire logic                       nrst_in,
  input  wire logic                       ce_in,
  input  wire logic [15:0]                instr_in,
  input  wire logic [7:0]                 reg_rdata_in,
  input  wire logic                       acc_wr_in,
  input  wire logic [7:0]                 acc_wdata_in,
  input  wire logic                       bank_select_wr_in,
  input  wire logic [3:0]                 bank_select_wdata_in,
  input  wire logic                       wdt_tick_in,
  input  wire logic                       sleep_enter_in,
  output logic [1:0]                      phase_out,
  output logic [ccce_pkg::PC_W-1:0]       pc_out,
  output logic [ccce_pkg::PC_W-1:0]       stack_top_out,
  output logic                            refill_out,
  output ccce_pkg::ccce_req_t             reg_req_out,
  output logic [7:0]                      accumulator_out,
  output logic [7:0]                      flags_out,
  output logic [3:0]                      bank_select_reg_out,
  output logic [7:0]                      shadow_accumulator_out,
  output logic [7:0]                      shadow_flags_out,
  output logic [3:0]                      shadow_bank_select_out,
  output logic [ccce_pkg::WDT_W-1:0]      watchdog_counter_out,
  output logic                            watchdog_expiry_flag_n_out,
  output logic                            sleep_flag_n_out
);
  import ccce_pkg::*;

  ccce_phase_t        phase_r;
  ccce_op_t           op_r;
  logic [15:0]        ir_r;
  logic               refill_r;
  logic [PC_W-1:0]    pc_r;
  logic [PC_W-1:0]    stack_top_r;
  logic [7:0]         result_r;
  logic [7:0]         acc_r;
  logic [7:0]         flags_r;
  logic [3:0]         bank_r;
  logic [7:0]         sh_acc_r;
  logic [7:0]         sh_flags_r;
  logic [3:0]         sh_bank_r;
  logic [WDT_W-1:0]   wdt_r;
  logic [POST_W-1:0]  post_r;
  logic               expiry_n_r;
  logic               sleep_n_r;
  ccce_req_t          req_r;

  // opcode decode; the kick is a full-word match, the others carry operand bits
  function automatic ccce_op_t decode_op(input logic [15:0] w);
    ccce_op_t op;
    op = OP_NONE;
    if (w[15:9] == OPC_ZERO) begin
      op = OP_ZERO;
    end else if (w[15:10] == OPC_INVERT) begin
      op = OP_INVERT;
    end else if (w[15:9] == OPC_CALL) begin
      op = OP_CALL;
    end else if (w == OPC_KICK) begin
      op = OP_KICK;
    end
    return op;
  endfunction

  // access bank splits at 0x80: low half in bank 0, high half in the top bank
  function automatic logic [DADDR_W-1:0] data_addr(input logic a, input logic [7:0] f, input logic [3:0] bank_select_reg);
    logic [3:0] bank;
    bank = a ? bank_select_reg : (f[7] ? ACC_BANK_HI : ACC_BANK_LO);
    return {bank, f};
  endfunction

  // named decode wires for the current instruction
  ccce_op_t          dec_op;
  logic [DADDR_W-1:0] file_addr;
  logic [7:0]        inv_val;
  logic              is_file;
  logic              dest_reg;
  logic [PC_W-1:0]   call_target;
  logic              post_wrap;
  logic              wdt_wrap;

  assign dec_op      = refill_r ? OP_NONE : decode_op(instr_in);
  assign file_addr   = data_addr(ir_r[BIT_ACCESS], ir_r[7:0], bank_r);
  assign inv_val     = ~reg_rdata_in;
  assign is_file     = (op_r == OP_ZERO) || (op_r == OP_INVERT);
  assign dest_reg    = ir_r[BIT_DEST];
  assign call_target = {instr_in[11:0], ir_r[7:0], 1'b0};
  assign post_wrap   = wdt_tick_in && (post_r == POST_MAX);
  assign wdt_wrap    = post_wrap && (wdt_r == WDT_MAX);

  // quarter phase sequencer and instruction latch
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase_r <= PH_DECODE;
      op_r    <= OP_NONE;
      ir_r    <= 16'h0000;
    end else if (ce_in) begin
      unique case (phase_r)
        PH_DECODE: phase_r <= PH_READ;
        PH_READ:   phase_r <= PH_PROC;
        PH_PROC:   phase_r <= PH_WRITE;
        PH_WRITE:  phase_r <= PH_DECODE;
      endcase
      if (phase_r == PH_DECODE) begin
        op_r <= dec_op;
        ir_r <= instr_in;
      end
    end
  end

  // register file strobes: read in Q2, write in Q4, idle otherwise
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      req_r <= '0;
    end else if (ce_in) begin
      req_r.rd <= (phase_r == PH_DECODE) && (dec_op == OP_INVERT || dec_op == OP_ZERO);
      req_r.wr <= (phase_r == PH_PROC) && (op_r == OP_ZERO || (op_r == OP_INVERT && dest_reg));
      if (phase_r == PH_DECODE) begin
        req_r.addr <= data_addr(instr_in[BIT_ACCESS], instr_in[7:0], bank_r);
      end else if (phase_r == PH_PROC && is_file) begin
        req_r.addr  <= file_addr;
        req_r.wdata <= (op_r == OP_ZERO) ? 8'h00 : result_r;
      end
    end
  end

  // process step: result formed in Q3 from the data read in Q2
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      result_r <= 8'h00;
    end else if (ce_in && phase_r == PH_READ && is_file) begin
      result_r <= (op_r == OP_ZERO) ? 8'h00 : inv_val;
    end
  end

  // program counter and return stack top; the refill cycle leaves pc on the target
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pc_r        <= PC_RST;
      stack_top_r <= PC_RST;
      refill_r    <= 1'b0;
    end else if (ce_in) begin
      if (phase_r == PH_PROC && op_r == OP_CALL) begin
        stack_top_r <= pc_r + CALL_RET;
      end
      if (phase_r == PH_WRITE) begin
        if (op_r == OP_CALL && instr_in[15:12] == OPC_CALL2) begin
          pc_r     <= call_target;
          refill_r <= 1'b1;
        end else begin
          if (!refill_r) begin
            pc_r <= pc_r + PC_STEP;
          end
          refill_r <= 1'b0;
        end
      end
    end
  end

  // working registers; the instruction's own write wins over the side load port
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      acc_r   <= ACC_RST;
      flags_r <= FLAGS_RST;
      bank_r  <= BANK_RST;
    end else if (ce_in) begin
      if (phase_r == PH_WRITE && op_r == OP_INVERT && !dest_reg) begin
        acc_r <= result_r;
      end else if (acc_wr_in) begin
        acc_r <= acc_wdata_in;
      end
      if (bank_select_wr_in) begin
        bank_r <= bank_select_wdata_in;
      end
      if (phase_r == PH_WRITE && op_r == OP_ZERO) begin
        flags_r[FLAG_Z] <= 1'b1;
      end else if (phase_r == PH_WRITE && op_r == OP_INVERT) begin
        flags_r[FLAG_N] <= result_r[7];
        flags_r[FLAG_Z] <= (result_r == 8'h00);
      end
    end
  end

  // fast-call shadows, taken in Q3 alongside the push
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sh_acc_r   <= ACC_RST;
      sh_flags_r <= FLAGS_RST;
      sh_bank_r  <= BANK_RST;
    end else if (ce_in && phase_r == PH_PROC && op_r == OP_CALL && ir_r[BIT_FAST]) begin
      sh_acc_r   <= acc_r;
      sh_flags_r <= flags_r;
      sh_bank_r  <= bank_r;
    end
  end

  // watchdog; the kick in Q3 wins over a tick or a sleep entry in the same cycle
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wdt_r      <= WDT_RST;
      post_r     <= POST_RST;
      expiry_n_r <= 1'b1;
      sleep_n_r  <= 1'b1;
    end else if (ce_in) begin
      if (phase_r == PH_PROC && op_r == OP_KICK) begin
        wdt_r      <= WDT_RST;
        post_r     <= POST_RST;
        expiry_n_r <= 1'b1;
        sleep_n_r  <= 1'b1;
      end else begin
        if (wdt_tick_in) begin
          post_r <= post_r + 7'h01;
        end
        if (post_wrap) begin
          wdt_r <= wdt_r + 8'h01;
        end
        if (wdt_wrap) begin
          expiry_n_r <= 1'b0;
        end
        if (sleep_enter_in) begin
          sleep_n_r <= 1'b0;
        end
      end
    end
  end

  // every output straight from a flip-flop
  assign phase_out                  = phase_r;
  assign pc_out                     = pc_r;
  assign stack_top_out              = stack_top_r;
  assign refill_out                 = refill_r;
  assign reg_req_out                = req_r;
  assign accumulator_out            = acc_r;
  assign flags_out                  = flags_r;
  assign bank_select_reg_out        = bank_r;
  assign shadow_accumulator_out     = sh_acc_r;
  assign shadow_flags_out           = sh_flags_r;
  assign shadow_bank_select_out     = sh_bank_r;
  assign watchdog_counter_out       = wdt_r;
  assign watchdog_expiry_flag_n_out = expiry_n_r;
  assign sleep_flag_n_out           = sleep_n_r;

endmodule

// file: ccce_assertions.sv
// concurrent checks on the execution slice ports
`timescale 1ns/1ns
module ccce_assertions (
  input wire logic                        ref_clk_in,
  input wire logic                        nrst_in,
  input wire logic                        ce_in,
  input wire logic [15:0]                 instr_in,
  input wire logic [7:0]                  reg_rdata_in,
  input wire logic [1:0]                  phase_out,
  input wire logic [ccce_pkg::PC_W-1:0]   pc_out,
  input wire logic [ccce_pkg::PC_W-1:0]   stack_top_out,
  input wire logic                        refill_out,
  input wire ccce_pkg::ccce_req_t         reg_req_out,
  input wire logic [7:0]                  accumulator_out,
  input wire logic [7:0]                  flags_out,
  input wire logic [3:0]                  bank_select_reg_out,
  input wire logic [7:0]                  shadow_accumulator_out,
  input wire logic [7:0]                  shadow_flags_out,
  input wire logic [3:0]                  shadow_bank_select_out,
  input wire logic [ccce_pkg::WDT_W-1:0]  watchdog_counter_out,
  input wire logic                        watchdog_expiry_flag_n_out,
  input wire logic                        sleep_flag_n_out
);
  import ccce_pkg::*;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  // decode points; words seen during the refill cycle never start anything
  wire start = (phase_out == 2'h0) && !refill_out;
  wire call1 = start && (instr_in[15:9] == OPC_CALL);
  wire inv1  = start && (instr_in[15:10] == OPC_INVERT);
  sequence call_ok;
    call1 ##3 (phase_out == 2'h3) && (instr_in[15:12] == OPC_CALL2);
  endsequence
  AST_PHASE_STEP: assert property (ce_in |=> phase_out == $past(phase_out) + 2'h1)
    else $error("phase did not advance");
  AST_FREEZE: assert property (!ce_in |=> $stable(phase_out) && $stable(pc_out) && $stable(reg_req_out))
    else $error("state moved while frozen");
  AST_WR_Q4: assert property (reg_req_out.wr |-> phase_out == 2'h3)
    else $error("write outside Q4");
  AST_ZERO: assert property (start && instr_in[15:9] == OPC_ZERO |-> ##3 reg_req_out.wr && reg_req_out.wdata == 8'h00 ##1 flags_out[FLAG_Z])
    else $error("zeroing write or flag wrong");
  AST_ACCESS: assert property (start && instr_in[15:9] == OPC_ZERO && !instr_in[BIT_ACCESS] |=> reg_req_out.addr == {($past(instr_in[7]) ? ACC_BANK_HI : ACC_BANK_LO), $past(instr_in[7:0])})
    else $error("access bank address wrong");
  AST_STACK: assert property (call1 |-> ##3 stack_top_out == pc_out + CALL_RET)
    else $error("return address wrong");
  AST_TARGET: assert property (call_ok |=> pc_out == {$past(instr_in[11:0]), $past(instr_in[7:0], 4), 1'b0})
    else $error("call target wrong");
  AST_REFILL: assert property (call_ok |=> refill_out [*4] ##1 !refill_out)
    else $error("refill cycle length wrong");
  AST_FAST: assert property (call1 && instr_in[BIT_FAST] |-> ##3 shadow_accumulator_out == $past(accumulator_out) && shadow_flags_out == $past(flags_out) && shadow_bank_select_out == $past(bank_select_reg_out))
    else $error("shadow copy wrong");
  AST_KICK: assert property (start && instr_in == OPC_KICK |-> ##3 watchdog_counter_out == WDT_RST && watchdog_expiry_flag_n_out && sleep_flag_n_out)
    else $error("watchdog kick incomplete");
  AST_INV_REG: assert property (inv1 && instr_in[BIT_DEST] |-> ##3 reg_req_out.wr && reg_req_out.wdata == ~$past(reg_rdata_in, 2))
    else $error("inverted write wrong");
  AST_INV_ACC: assert property (inv1 && !instr_in[BIT_DEST] |-> ##3 !reg_req_out.wr ##1 accumulator_out == ~$past(reg_rdata_in, 3))
    else $error("inverted accumulator wrong");
  // main scenarios reached
  cover property (call_ok);
  cover property (inv1);
  cover property (start && instr_in == OPC_KICK);
endmodule
bind ccce_exec ccce_assertions u_chk (.ref_clk_in, .nrst_in, .ce_in, .instr_in, .reg_rdata_in, .phase_out, .pc_out,
  .stack_top_out, .refill_out, .reg_req_out, .accumulator_out, .flags_out, .bank_select_reg_out,
  .shadow_accumulator_out, .shadow_flags_out, .shadow_bank_select_out, .watchdog_counter_out,
  .watchdog_expiry_flag_n_out, .sleep_flag_n_out);

// file: ccce_rf_model.sv
// data register file standing on the far side of the read / write strobes
`timescale 1ns/1ns
module ccce_rf_model (
  input  wire logic                 ref_clk_in,
  input  wire ccce_pkg::ccce_req_t  req_in,
  output logic [7:0]                rdata_out
);
  import ccce_pkg::*;
  logic [7:0] mem [0:4095];
  logic [7:0] last_r;
  initial last_r = 8'h00;
  // released bus shows the inverse of the last value, so a late sample cannot match by luck
  assign rdata_out = req_in.rd ? mem[req_in.addr] : ~last_r;
  always @(posedge ref_clk_in) begin
    if (req_in.rd) last_r <= mem[req_in.addr];
    if (req_in.wr) mem[req_in.addr] <= req_in.wdata;
  end
endmodule

// file: tb_top.sv
// self-checking bench for the execution slice
`timescale 1ns/1ns
module tb_top;
  import ccce_pkg::*;
  logic                ref_clk_in, nrst_in, ce_in, acc_wr_in, bank_select_wr_in, wdt_tick_in, sleep_enter_in;
  logic [15:0]         instr_in;
  logic [7:0]          reg_rdata_in, acc_wdata_in, accumulator_out, flags_out, shadow_accumulator_out, shadow_flags_out;
  logic [3:0]          bank_select_wdata_in, bank_select_reg_out, shadow_bank_select_out;
  logic [1:0]          phase_out;
  logic [PC_W-1:0]     pc_out, stack_top_out, pc_e;
  logic                refill_out, watchdog_expiry_flag_n_out, sleep_flag_n_out;
  ccce_req_t           reg_req_out;
  logic [WDT_W-1:0]    watchdog_counter_out;
  int                  errors, check_count;
  ccce_exec u_dut (.ref_clk_in, .nrst_in, .ce_in, .instr_in, .reg_rdata_in, .acc_wr_in, .acc_wdata_in,
    .bank_select_wr_in, .bank_select_wdata_in, .wdt_tick_in, .sleep_enter_in, .phase_out, .pc_out,
    .stack_top_out, .refill_out, .reg_req_out, .accumulator_out, .flags_out, .bank_select_reg_out,
    .shadow_accumulator_out, .shadow_flags_out, .shadow_bank_select_out, .watchdog_counter_out,
    .watchdog_expiry_flag_n_out, .sleep_flag_n_out);
  ccce_rf_model u_rf (.ref_clk_in, .req_in(reg_req_out), .rdata_out(reg_rdata_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one instruction cycle: word set at a falling edge, results settled four edges later
  task automatic op(input logic [15:0] w);
    instr_in = w;
    repeat (4) @(negedge ref_clk_in);
    pc_e = pc_e + PC_STEP;
  endtask
  // two-word call, then a refill cycle carrying a zeroing word that must be dropped
  task automatic call(input logic s, input logic [19:0] k);
    logic [PC_W-1:0] ret;
    ret = pc_e + 21'h000004;
    instr_in = {OPC_CALL, s, k[7:0]};
    repeat (3) @(negedge ref_clk_in);
    instr_in = {OPC_CALL2, k[19:8]};
    @(negedge ref_clk_in);
    pc_e = {k, 1'b0};
    chk(stack_top_out, ret);
    chk(pc_out, pc_e);
    chk(refill_out, 1'b1);
    instr_in = {OPC_ZERO, 1'b1, 8'h21};
    repeat (4) @(negedge ref_clk_in);
    chk(pc_out, pc_e);
    chk(u_rf.mem[12'h321], 8'h5a);
    chk(refill_out, 1'b0);
  endtask
  task automatic test_done;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {nrst_in, acc_wr_in, bank_select_wr_in, wdt_tick_in, sleep_enter_in} = 5'h00;
    ce_in = 1'b1; // held high except for one frozen stretch later in the run
    instr_in = 16'h0000;
    acc_wdata_in = 8'h3c;
    bank_select_wdata_in = 4'h3;
    {pc_e, errors, check_count} = '0;
    u_rf.mem[12'h320] = 8'h5a;
    u_rf.mem[12'h321] = 8'h5a;
    u_rf.mem[12'h322] = 8'h13;
    u_rf.mem[12'h3a0] = 8'hff;
    u_rf.mem[12'hf85] = 8'h77;
    u_rf.mem[12'h010] = 8'h66;
    repeat (2) @(negedge ref_clk_in);
    nrst_in = 1'b1;
    // bank 3 and accumulator 0x3c loaded alongside a no-op
    {acc_wr_in, bank_select_wr_in} = 2'b11;
    op(16'h0000);
    {acc_wr_in, bank_select_wr_in} = 2'b00;
    op({OPC_ZERO, 1'b1, 8'h20});
    chk(u_rf.mem[12'h320], 8'h00);
    chk(flags_out[FLAG_Z], 1'b1);
    op({OPC_ZERO, 1'b0, 8'h85});
    chk(u_rf.mem[12'hf85], 8'h00);
    op({OPC_ZERO, 1'b0, 8'h10});
    chk(u_rf.mem[12'h010], 8'h00);
    op({OPC_INVERT, 1'b1, 1'b1, 8'h22});
    chk(u_rf.mem[12'h322], 8'hec);
    chk(flags_out, 8'h10);
    op({OPC_INVERT, 1'b0, 1'b1, 8'ha0});
    chk(accumulator_out, 8'h00);
    chk(flags_out, 8'h04);
    chk(u_rf.mem[12'h3a0], 8'hff);
    acc_wr_in = 1'b1;
    op(16'h0000);
    acc_wr_in = 1'b0;
    chk(pc_out, pc_e);
    call(1'b1, 20'hab123);
    chk(shadow_accumulator_out, 8'h3c);
    chk(shadow_flags_out, 8'h04);
    chk(shadow_bank_select_out, 4'h3);
    acc_wdata_in = 8'h11;
    acc_wr_in = 1'b1;
    op(16'h0000);
    acc_wr_in = 1'b0;
    call(1'b0, 20'h00010);
    chk(shadow_accumulator_out, 8'h3c);
    // a frozen stretch inside a no-op must hold the phase; the word is replaced before its decode edge
    instr_in = 16'h0000;
    @(negedge ref_clk_in);
    ce_in = 1'b0;
    repeat (3) @(negedge ref_clk_in);
    chk(phase_out, 2'h1);
    ce_in = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    pc_e = pc_e + PC_STEP;
    // sleep entry held over a whole no-op, so the instruction cycle stays aligned
    sleep_enter_in = 1'b1;
    op(16'h0000);
    sleep_enter_in = 1'b0;
    chk(sleep_flag_n_out, 1'b0);
    // a tick run past one full counter wrap drops the expiry flag and leaves the counter off zero
    wdt_tick_in = 1'b1;
    repeat (8267) op(16'h0000);
    wdt_tick_in = 1'b0;
    chk(watchdog_counter_out != WDT_RST, 1'b1);
    chk(watchdog_expiry_flag_n_out, 1'b0);
    op(OPC_KICK);
    chk(watchdog_counter_out, WDT_RST);
    chk(sleep_flag_n_out, 1'b1);
    chk(watchdog_expiry_flag_n_out, 1'b1);
    test_done;
  end
  // hang guard at 10000 instruction cycles, about a fifth beyond the roughly 8300 needed
  initial begin
    #400000;
    errors++;
    test_done;
  end
endmodule
